// file: include/pwm_cutoff_defs.svh
/*
  Constants of the two-channel PWM timer with forced cutoff.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PWM_CUTOFF_DEFS_SVH
`define PWM_CUTOFF_DEFS_SVH

`define CNT_W      16
`define PRESC_W    5
`define PIN_A0     0
`define PIN_B0     1
`define PIN_C0     2
`define PIN_D0     3
`define PIN_A1     4
`define PIN_B1     5
`define PIN_C1     6
`define PIN_D1     7
`define PINS_RST   8'h00
`define CNT_RST    16'h0000

`endif

// file: include/pwm_cutoff_pkg.sv
/*
  Types of the two-channel PWM timer: operating mode and count source.
  Assumes pwm_cutoff_defs.svh is on the include path.
*/
`default_nettype none
`include "pwm_cutoff_defs.svh"

package pwm_cutoff_pkg;
  typedef enum logic [2:0] {
    MODE_TIMER,
    MODE_PWM,
    MODE_RSYNC,
    MODE_COMPL,
    MODE_THIRD
  } pwm_mode_e;

  typedef enum logic [2:0] {
    SRC_CLK,
    SRC_DIV2,
    SRC_DIV4,
    SRC_DIV8,
    SRC_DIV32,
    SRC_FAST_OSC,
    SRC_EXT
  } count_src_e;
endpackage

`default_nettype wire

// file: hw/pwm_channel.sv
/*
  One timer channel: 16-bit counter that clears at general register A,
  or counts up to it and back to zero in triangle mode.
  Assumes a one-cycle count tick from the parent and synchronous inputs.
*/
`default_nettype none
`include "pwm_cutoff_defs.svh"

module pwm_channel
  import pwm_cutoff_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              tick_i,
  input  wire logic              run_i,
  input  wire logic              updown_i,
  input  wire logic              stop_on_match_i,
  input  wire logic [`CNT_W-1:0] period_i,
  output logic      [`CNT_W-1:0] cnt_o,
  output logic                   match_a_o,
  output logic                   underflow_o
);
  typedef struct packed {
    logic [`CNT_W-1:0] cnt;
    logic              down;
    logic              stopped;
    logic              match_a;
    logic              udf;
  } chan_s;

  chan_s r, nxt;

  always_comb begin
    nxt         = r;
    nxt.match_a = 1'b0;
    nxt.udf     = 1'b0;
    if (!run_i) begin
      nxt.cnt     = `CNT_RST;
      nxt.down    = 1'b0;
      nxt.stopped = 1'b0;
    end else if (tick_i && !r.stopped) begin
      if (updown_i) begin
        if (!r.down) begin
          if (r.cnt >= period_i) begin
            nxt.down    = 1'b1;
            nxt.cnt     = r.cnt - `CNT_W'(1);
            nxt.match_a = 1'b1;
          end else begin
            nxt.cnt = r.cnt + `CNT_W'(1);
          end
        end else if (r.cnt == `CNT_RST) begin
          nxt.down = 1'b0;
          nxt.cnt  = r.cnt + `CNT_W'(1);
          nxt.udf  = 1'b1;
        end else begin
          nxt.cnt = r.cnt - `CNT_W'(1);
        end
      end else if (r.cnt == period_i) begin
        nxt.match_a = 1'b1;
        nxt.cnt     = `CNT_RST;
        // Stop holds until the channel is restarted
        nxt.stopped = stop_on_match_i; // R3
      end else begin
        nxt.cnt = r.cnt + `CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign cnt_o       = r.cnt;
  assign match_a_o   = r.match_a;
  assign underflow_o = r.udf;
endmodule

`default_nettype wire

// file: hw/pwm_cutoff_timer.sv
/*
  Two-channel timer/PWM with selectable count source and forced cutoff.
  Assumes all inputs synchronous to sys_clk_i; software control bits
  arrive as plain ports; events leave as one-cycle pulses to the
  event link. Pin order: A0 B0 C0 D0 A1 B1 C1 D1 from bit 0 up.
*/
// Contract
// R1 - Timer, PWM, reset-sync, complementary, third variant modes
// R2 - Count source selectable; external clock barred in third
// R3 - Per channel stop or continue at match A
// R4 - Pin low keeps outputs cut off
// R5 - One event pulse gives one latched cutoff
// R6 - Software routes event link, sets both select bits
// R7 - Cutoff holds until software clears, pin high first
// R8 - Cutoff pin levels from per-pin cutoff state
// R9 - No direct A/D trigger; events only
// R10 - Complementary peak event from channel 0 match A
// R11 - Complementary trough event from channel 1 underflow
// R12 - Event outputs are single-clock pulses
`default_nettype none
`include "pwm_cutoff_defs.svh"

module pwm_cutoff_timer
  import pwm_cutoff_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  input  wire pwm_mode_e         mode_i,
  input  wire count_src_e        count_src_i,
  input  wire logic              fast_onchip_osc_clock_i,
  input  wire logic              external_count_clock_i,
  input  wire logic [1:0]        count_start_i,
  input  wire logic [1:0]        stop_on_match_i,
  input  wire logic [`CNT_W-1:0] general_reg_a0_i,
  input  wire logic [`CNT_W-1:0] general_reg_a1_i,
  input  wire logic [`CNT_W-1:0] general_reg_b0_i,
  input  wire logic [`CNT_W-1:0] general_reg_b1_i,
  input  wire logic              cutoff_pin_enable_i,
  input  wire logic              external_cutoff_input_i,
  input  wire logic              event_link_input_zero_i,
  input  wire logic              event_link_input_one_i,
  input  wire logic [1:0]        event_capture_select_i,
  input  wire logic [1:0]        event_cutoff_enable_i,
  input  wire logic              forced_cutoff_clear_i,
  input  wire logic [7:0]        cutoff_level_i,
  input  wire logic [7:0]        cutoff_drive_i,
  output logic      [7:0]        pwm_o,
  output logic      [7:0]        pwm_oe_o,
  output logic                   forced_cutoff_flag_o,
  output logic                   evt_peak_o,
  output logic                   evt_trough_o,
  output logic                   evt_match_a1_o
);
  typedef struct packed {
    logic [`PRESC_W-1:0] presc;
    logic                ext_q;
    logic [1:0]          tog;
    logic                flag;
    logic [7:0]          pins;
    logic [7:0]          oe;
    logic                peak;
    logic                trough;
    logic                cma1;
  } top_s;

  top_s r, nxt;

  logic              tick;
  logic              updown;
  logic              run1;
  logic              ext_edge;
  logic              cut_set;
  logic [`CNT_W-1:0] period1;
  logic [`CNT_W-1:0] cnt0;
  logic [`CNT_W-1:0] cnt1;
  logic              ma0;
  logic              ma1;
  logic              udf0;
  logic              udf1;

  assign updown  = (mode_i == MODE_COMPL);
  // Channel 1 tracks channel 0 in the paired modes
  assign run1    = (mode_i == MODE_COMPL || mode_i == MODE_RSYNC)
                   ? count_start_i[0] : count_start_i[1];
  assign period1 = updown ? general_reg_a0_i : general_reg_a1_i;
  assign ext_edge = external_count_clock_i && !r.ext_q;

  always_comb begin
    unique case (count_src_i)
      SRC_CLK:      tick = 1'b1;
      SRC_DIV2:     tick = r.presc[0];
      SRC_DIV4:     tick = &r.presc[1:0];
      SRC_DIV8:     tick = &r.presc[2:0];
      SRC_DIV32:    tick = &r.presc[4:0];
      SRC_FAST_OSC: tick = fast_onchip_osc_clock_i;
      SRC_EXT:      tick = ext_edge && (mode_i != MODE_THIRD); // R2
      default:      tick = 1'b0;
    endcase
  end

  pwm_channel u_ch0 (
    .sys_clk_i       (sys_clk_i),
    .nrst_i          (nrst_i),
    .tick_i          (tick),
    .run_i           (count_start_i[0]),
    .updown_i        (updown),
    .stop_on_match_i (stop_on_match_i[0]),
    .period_i        (general_reg_a0_i),
    .cnt_o           (cnt0),
    .match_a_o       (ma0),
    .underflow_o     (udf0)
  );

  pwm_channel u_ch1 (
    .sys_clk_i       (sys_clk_i),
    .nrst_i          (nrst_i),
    .tick_i          (tick),
    .run_i           (run1),
    .updown_i        (updown),
    .stop_on_match_i (stop_on_match_i[1]),
    .period_i        (period1),
    .cnt_o           (cnt1),
    .match_a_o       (ma1),
    .underflow_o     (udf1)
  );

  // Pin low is a level source; event sources latch once
  assign cut_set =
      (cutoff_pin_enable_i && !external_cutoff_input_i) || // R4
      (event_link_input_zero_i && event_capture_select_i[0]
       && event_cutoff_enable_i[0]) ||                     // R5
      (event_link_input_one_i && event_capture_select_i[1]
       && event_cutoff_enable_i[1]);                       // R5

  always_comb begin
    nxt       = r;
    nxt.presc = r.presc + `PRESC_W'(1);
    nxt.ext_q = external_count_clock_i;
    // Set wins over clear, so a held-low pin defeats the clear
    if (cut_set) begin
      nxt.flag = 1'b1; // R7
    end else if (forced_cutoff_clear_i) begin
      nxt.flag = 1'b0; // R7
    end
    if (ma0) begin
      nxt.tog[0] = !r.tog[0];
    end
    if (ma1) begin
      nxt.tog[1] = !r.tog[1];
    end
    nxt.pins = `PINS_RST;
    nxt.oe   = 8'hff;
    unique case (mode_i) // R1
      MODE_TIMER: begin
        nxt.pins[`PIN_A0] = r.tog[0];
        nxt.pins[`PIN_B0] = (cnt0 >= general_reg_b0_i);
        nxt.pins[`PIN_A1] = r.tog[1];
        nxt.pins[`PIN_B1] = (cnt1 >= general_reg_b1_i);
      end
      MODE_PWM: begin
        nxt.pins[`PIN_B0] = (cnt0 < general_reg_b0_i);
        nxt.pins[`PIN_B1] = (cnt1 < general_reg_b1_i);
      end
      MODE_RSYNC, MODE_COMPL: begin
        nxt.pins[`PIN_A0] = r.tog[0];
        nxt.pins[`PIN_B0] = (cnt0 < general_reg_b0_i);
        nxt.pins[`PIN_D0] = !(cnt0 < general_reg_b0_i);
        nxt.pins[`PIN_B1] = (cnt1 < general_reg_b1_i);
        nxt.pins[`PIN_D1] = !(cnt1 < general_reg_b1_i);
      end
      MODE_THIRD: begin
        nxt.pins[`PIN_A0] = (cnt0 >= general_reg_b0_i)
                            && (cnt0 < general_reg_a1_i);
        nxt.pins[`PIN_B0] = (cnt0 >= general_reg_b1_i);
      end
      default: begin
        nxt.oe = 8'h00;
      end
    endcase
    // Cutoff levels come from the per-pin cutoff state
    if (nxt.flag) begin
      nxt.pins = cutoff_level_i; // R8
      nxt.oe   = cutoff_drive_i; // R8
    end
    // A/D start exists only by routing these through the event link
    nxt.peak   = ma0 && updown;  // R9 R10 R12
    nxt.trough = udf1 && updown; // R9 R11 R12
    nxt.cma1   = ma1 && !updown; // R12
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign pwm_o                = r.pins;
  assign pwm_oe_o             = r.oe;
  assign forced_cutoff_flag_o = r.flag;
  assign evt_peak_o           = r.peak;
  assign evt_trough_o         = r.trough;
  assign evt_match_a1_o       = r.cma1;

  property p_pin_hold;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (cutoff_pin_enable_i && !external_cutoff_input_i)
      |=> forced_cutoff_flag_o;
  endproperty
  a_pin_hold: assert property (p_pin_hold) // R4
    else $error("cutoff not held while pin low");

  property p_evt_cut;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (event_link_input_zero_i && event_capture_select_i[0]
     && event_cutoff_enable_i[0])
      |=> forced_cutoff_flag_o;
  endproperty
  a_evt_cut: assert property (p_evt_cut) // R5
    else $error("event did not cut off outputs");

  property p_flag_stays;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (forced_cutoff_flag_o && !forced_cutoff_clear_i)
      |=> forced_cutoff_flag_o;
  endproperty
  a_flag_stays: assert property (p_flag_stays) // R7
    else $error("cutoff released without clear");

  property p_clear;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (forced_cutoff_clear_i && !cut_set) |=> !forced_cutoff_flag_o;
  endproperty
  a_clear: assert property (p_clear) // R7
    else $error("clear did not release cutoff");

  property p_cut_level;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    forced_cutoff_flag_o |-> (pwm_o == $past(cutoff_level_i))
                             && (pwm_oe_o == $past(cutoff_drive_i));
  endproperty
  a_cut_level: assert property (p_cut_level) // R8
    else $error("cutoff pin level wrong");

  property p_no_ext_third;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (mode_i == MODE_THIRD && count_src_i == SRC_EXT) |-> !tick;
  endproperty
  a_no_ext_third: assert property (p_no_ext_third) // R2
    else $error("external clock counted in third variant");

  property p_stop;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (ma0 && !updown && stop_on_match_i[0] && count_start_i[0])
      |=> ($stable(cnt0) || !count_start_i[0]);
  endproperty
  a_stop: assert property (p_stop) // R3
    else $error("counter ran after stop at match");

  property p_peak;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    evt_peak_o |-> $past(ma0) && $past(mode_i) == MODE_COMPL;
  endproperty
  a_peak: assert property (p_peak) // R10
    else $error("peak event without channel 0 match");

  property p_trough;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    evt_trough_o |-> $past(udf1) && $past(mode_i) == MODE_COMPL;
  endproperty
  a_trough: assert property (p_trough) // R11
    else $error("trough event without channel 1 underflow");

  property p_pulse;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (evt_peak_o || evt_trough_o) |=> !(evt_peak_o || evt_trough_o);
  endproperty
  a_pulse: assert property (p_pulse) // R12
    else $error("event longer than one cycle");

  property p_compl_pair;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (!forced_cutoff_flag_o && $past(mode_i) == MODE_COMPL)
      |-> pwm_o[`PIN_D0] == !pwm_o[`PIN_B0];
  endproperty
  a_compl_pair: assert property (p_compl_pair) // R1
    else $error("complementary pair not inverse");
endmodule

`default_nettype wire

// file: tb/pwm_far_side.sv
/*
  Far side of the PWM timer: cutoff pin, event link pulses, pin wires.
  Assumes commands from the bench, all synchronous to sys_clk_i.
*/
`default_nettype none

module pwm_far_side (
  input  wire logic       sys_clk_i,
  input  wire logic       pin_low_i,
  input  wire logic [1:0] ev_req_i,
  input  wire logic [7:0] pwm_i,
  input  wire logic [7:0] oe_i,
  output logic            cutoff_pin_o,
  output logic [1:0]      ev_o,
  output logic [7:0]      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ev_r = 2'b00;
  logic [7:0] last_r = 8'h00;
  always @(posedge sys_clk_i) begin
    ev_r <= ev_req_i;
    last_r <= pin_o;
  end
  // One request gives a one-cycle event pulse
  assign ev_o = ev_r;
  assign cutoff_pin_o = ~pin_low_i;
  // Released pins flip so a stale level cannot pass a check
  assign pin_o = (oe_i & pwm_i) | (~oe_i & ~last_r);
endmodule

`default_nettype wire

// file: tb/tb_top.sv
/*
  Self-checking bench of the PWM timer with forced cutoff.
  Assumes the design files and package compiled first.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pwm_cutoff_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  pwm_mode_e   mode = MODE_TIMER;
  count_src_e  src = SRC_CLK;
  logic        osc = 1'b0, ext_clk = 1'b0, pin_en = 1'b0;
  logic        pin_low = 1'b0, clr = 1'b0;
  logic [1:0]  start = 2'b00, stop = 2'b00, sel = 2'b00;
  logic [1:0]  en = 2'b00, ev_req = 2'b00, ev;
  logic [15:0] ga0 = 16'h0004, ga1 = 16'h0001;
  logic [15:0] gb0 = 16'h0002, gb1 = 16'h0002;
  logic [7:0]  lvl = 8'ha5, drv = 8'h5a, pwm, oe, pin;
  logic        flag, peak, trough, m1, cut_pin;
  int          n_mismatch = 0, checked = 0, g, k;
  // pin_en pin_low ev_req[1:0] sel[1:0] en[1:0] expected_flag
  logic [8:0]  cut_tab [6] = '{9'b1_1_00_00_00_1, 9'b0_1_00_00_00_0,
    9'b0_0_01_11_11_1, 9'b0_0_10_11_11_1, 9'b0_0_01_01_00_0,
    9'b0_0_10_10_01_0};
  count_src_e  srcs [7] = '{SRC_CLK, SRC_DIV2, SRC_DIV4, SRC_DIV8,
    SRC_DIV32, SRC_FAST_OSC, SRC_EXT};
  int          gaps [7] = '{2, 4, 8, 16, 64, 4, 4};

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    osc <= ~osc;
    ext_clk <= ~ext_clk;
  end

  pwm_cutoff_timer pwm_cutoff_timer_inst (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .mode_i(mode),
    .count_src_i(src), .fast_onchip_osc_clock_i(osc),
    .external_count_clock_i(ext_clk), .count_start_i(start),
    .stop_on_match_i(stop), .general_reg_a0_i(ga0),
    .general_reg_a1_i(ga1), .general_reg_b0_i(gb0),
    .general_reg_b1_i(gb1), .cutoff_pin_enable_i(pin_en),
    .external_cutoff_input_i(cut_pin), .event_link_input_zero_i(ev[0]),
    .event_link_input_one_i(ev[1]), .event_capture_select_i(sel),
    .event_cutoff_enable_i(en), .forced_cutoff_clear_i(clr),
    .cutoff_level_i(lvl), .cutoff_drive_i(drv), .pwm_o(pwm),
    .pwm_oe_o(oe), .forced_cutoff_flag_o(flag), .evt_peak_o(peak),
    .evt_trough_o(trough), .evt_match_a1_o(m1));

  pwm_far_side pwm_far_side_inst (
    .sys_clk_i(sys_clk), .pin_low_i(pin_low), .ev_req_i(ev_req),
    .pwm_i(pwm), .oe_i(oe), .cutoff_pin_o(cut_pin), .ev_o(ev),
    .pin_o(pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  function automatic logic sig(input int w);
    return (w == 0) ? m1 : (w == 1) ? peak : trough;
  endfunction

  // Cycles between two pulses of the chosen event output
  task automatic gap_of(input int w, output int gp);
    int i;
    i = 0;
    @(negedge sys_clk);
    while (sig(w) !== 1'b1 && i < 300) begin
      @(negedge sys_clk);
      i++;
    end
    @(negedge sys_clk);
    check(sig(w), 1'b0);
    gp = 1;
    while (sig(w) !== 1'b1 && gp < 300) begin
      @(negedge sys_clk);
      gp++;
    end
  endtask

  // Pin back high first, only then the software clear
  task automatic clear_cut();
    cyc(1);
    pin_low <= 1'b0;
    cyc(1);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(1);
    @(negedge sys_clk);
    check(flag, 1'b0);
    check(oe, 8'hff);
  endtask

  task automatic restart(input logic [1:0] s);
    cyc(1);
    start <= 2'b00;
    // Two idle cycles let pulses of the old run drain
    cyc(2);
    start <= s;
  endtask

  initial begin
    cyc(20000);
    n_mismatch++;
    final_report();
  end

  initial begin
    cyc(2);
    @(negedge sys_clk);
    check(flag, 1'b0);
    check(oe, 8'h00);
    cyc(2);
    nrst <= 1'b1;
    foreach (cut_tab[i]) begin
      cyc(1);
      {pin_en, pin_low, ev_req, sel, en} <= cut_tab[i][8:1];
      cyc(1);
      ev_req <= 2'b00;
      cyc(3);
      @(negedge sys_clk);
      check(flag, cut_tab[i][0]);
      if (cut_tab[i][0]) begin
        check(oe, drv);
        check(pin & drv, lvl & drv);
      end
      clear_cut();
    end
    // Clear while the pin is still low must be refused
    cyc(1);
    pin_en <= 1'b1;
    pin_low <= 1'b1;
    cyc(2);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(2);
    @(negedge sys_clk);
    check(flag, 1'b1);
    clear_cut();
    foreach (srcs[i]) begin
      cyc(1);
      src <= srcs[i];
      restart(2'b11);
      gap_of(0, g);
      check(g, gaps[i]);
    end
    cyc(1);
    ga1 <= 16'h0003;
    src <= SRC_CLK;
    stop <= 2'b11;
    restart(2'b11);
    k = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (m1 === 1'b1) k++;
    end
    check(k, 1);
    cyc(1);
    mode <= MODE_COMPL;
    stop <= 2'b00;
    restart(2'b01);
    gap_of(1, g);
    check(g, 8);
    gap_of(2, g);
    check(g, 8);
    check(pwm[3], !pwm[1]);
    // Plain PWM: B high while count below compare
    cyc(1);
    mode <= MODE_PWM;
    restart(2'b11);
    cyc(5);
    k = 0;
    g = 0;
    repeat (20) begin
      @(negedge sys_clk);
      if (pwm[1] === 1'b1) k++;
      if (pwm[5] === 1'b1) g++;
    end
    check(k, 8);
    check(g, 10);
    // Reset-sync: channel 1 runs from channel 0 start
    cyc(1);
    mode <= MODE_RSYNC;
    restart(2'b01);
    k = 0;
    repeat (20) begin
      @(negedge sys_clk);
      if (m1 === 1'b1) k++;
      check(pwm[7], !pwm[5]);
    end
    check(k, 4);
    cyc(1);
    mode <= MODE_THIRD;
    src <= SRC_EXT;
    ga1 <= 16'h0004;
    gb0 <= 16'h0000;
    restart(2'b11);
    k = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (pwm[1:0] !== 2'b01) k++;
    end
    check(k, 0);
    final_report();
  end
endmodule

`default_nettype wire
